// ===== logic/ddrbi_pkg.sv
// Shared constants, command codes and helper functions for both ends of the DDR burst DRAM link.
package ddrbi_pkg;

  localparam int DQ_W         = 36;
  localparam int ADDR_W       = 20;
  localparam int BANK_W       = 4;
  localparam int STROBES      = 4;
  localparam int GROUP_W      = 9;
  localparam int GROUPS       = DQ_W / GROUP_W;
  localparam int BEAT_W       = 3;
  localparam int RD_LAT       = 3;
  localparam int BEATS_PER_CK = 2;
  localparam int MRS_BL_POS   = 0;
  localparam int MRS_DLL_POS  = 2;

  localparam logic [1:0] BL_CODE_2   = 2'h0;
  localparam logic [1:0] BL_CODE_4   = 2'h1;
  localparam logic [1:0] BL_CODE_8   = 2'h2;
  localparam logic [1:0] BL_CODE_RSV = 2'h3;
  localparam logic [1:0] BL_RESET    = BL_CODE_2;

  // Pin codes ordered as {cs_n, we_n, ref_n}.
  localparam logic [2:0] PIN_NOP   = 3'h7;
  localparam logic [2:0] PIN_READ  = 3'h3;
  localparam logic [2:0] PIN_WRITE = 3'h1;
  localparam logic [2:0] PIN_REF   = 3'h2;
  localparam logic [2:0] PIN_MRS   = 3'h0;

  typedef enum logic [2:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_REF, CMD_MRS} ddrbi_cmd_e;

  function automatic ddrbi_cmd_e cmd_decode(logic [2:0] pins);
    case (pins)
      PIN_READ:  return CMD_READ;
      PIN_WRITE: return CMD_WRITE;
      PIN_REF:   return CMD_REF;
      PIN_MRS:   return CMD_MRS;
      default:   return CMD_NOP;
    endcase
  endfunction : cmd_decode

  function automatic logic [2:0] cmd_encode(ddrbi_cmd_e cmd);
    case (cmd)
      CMD_READ:  return PIN_READ;
      CMD_WRITE: return PIN_WRITE;
      CMD_REF:   return PIN_REF;
      CMD_MRS:   return PIN_MRS;
      default:   return PIN_NOP;
    endcase
  endfunction : cmd_encode

  function automatic logic [3:0] burst_beats(logic [1:0] code);
    case (code)
      BL_CODE_4: return 4'h4;
      BL_CODE_8: return 4'h8;
      default:   return 4'h2;
    endcase
  endfunction : burst_beats

  // Groups 0 and 2 belong to strobe 0, groups 1 and 3 to strobe 1.
  function automatic int strobe_of_group(int g);
    return g % 2;
  endfunction : strobe_of_group

endpackage : ddrbi_pkg

// ===== logic/ddrbi_if.sv
// Link between the memory controller end and the DRAM device end, with common data bus resolution.
`timescale 1ns/1ps
interface ddrbi_if;
  logic                                cmd_clock;
  logic                                write_data_strobe;
  logic                                cs_n;
  logic                                we_n;
  logic                                ref_n;
  logic [ddrbi_pkg::BANK_W-1:0]        bank;
  logic [ddrbi_pkg::ADDR_W-1:0]        addr;
  logic [ddrbi_pkg::DQ_W-1:0]          dq_ctrl_out;
  logic                                dq_ctrl_oe;
  logic [ddrbi_pkg::DQ_W-1:0]          dq_dev_out;
  logic                                dq_dev_oe;
  logic [ddrbi_pkg::DQ_W-1:0]          dq;
  logic [ddrbi_pkg::STROBES-1:0]       read_strobe;
  logic                                data_valid;

  assign dq = dq_dev_oe ? dq_dev_out : (dq_ctrl_oe ? dq_ctrl_out : {ddrbi_pkg::DQ_W{1'b0}});

  modport dev (
    input  cmd_clock, write_data_strobe, cs_n, we_n, ref_n, bank, addr, dq,
    output dq_dev_out, dq_dev_oe, read_strobe, data_valid
  );

  modport ctrl (
    output cmd_clock, write_data_strobe, cs_n, we_n, ref_n, bank, addr, dq_ctrl_out, dq_ctrl_oe,
    input  dq, read_strobe, data_valid
  );
endinterface : ddrbi_if

// ===== logic/ddrbi_device.sv
// DRAM device end: command sampling, burst read and write, bank refresh and burst length setting.
`timescale 1ns/1ps
module ddrbi_device #(
  parameter int ROW_W  = 2,
  parameter int RD_LAT = ddrbi_pkg::RD_LAT
) (
  ddrbi_if.dev                        link,
  input  wire logic                   rst_n,
  output logic                        refresh_pulse,
  output logic [ddrbi_pkg::BANK_W-1:0] refresh_bank,
  output logic [ROW_W-1:0]            refresh_row,
  output logic [1:0]                  burst_len,
  output logic                        busy
);

  localparam int MEM_W = ddrbi_pkg::BANK_W + ROW_W + ddrbi_pkg::BEAT_W;
  localparam int MEM_N = 1 << MEM_W;

  if (ROW_W < 1 || ROW_W > 8 || RD_LAT < 1 || RD_LAT > 15) begin : g_bad_param
    $error("ddrbi_device: ROW_W must be 1..8 and RD_LAT 1..15");
  end

  typedef enum logic [1:0] {D_IDLE, D_READ, D_WRITE} ddrbi_dst_e;

  typedef struct packed {
    ddrbi_dst_e                               st;
    logic [1:0]                               bl_code;
    logic [ddrbi_pkg::BANK_W-1:0]             bank;
    logic [ROW_W-1:0]                         row;
    logic [ddrbi_pkg::BEAT_W-1:0]             beat;
    logic [3:0]                               cnt;
    logic [ROW_W-1:0]                         ref_ctr;
    logic [ROW_W-1:0]                         ref_row;
    logic [ddrbi_pkg::BANK_W-1:0]             ref_bank;
    logic                                     ref_pulse;
    logic [ddrbi_pkg::DQ_W-1:0]               rd_rise;
    logic [ddrbi_pkg::DQ_W-1:0]               rd_fall;
    logic                                     rd_valid;
    logic [MEM_N-1:0][ddrbi_pkg::DQ_W-1:0]    mem;
  } ddrbi_dev_s;

  ddrbi_dev_s                 q_ff;
  ddrbi_dev_s                 nxt_q;
  ddrbi_pkg::ddrbi_cmd_e      cmd;
  logic [ddrbi_pkg::DQ_W-1:0] wr_rise_ff;
  logic [ddrbi_pkg::DQ_W-1:0] wr_fall_ff;
  logic                       last_pair;

  function automatic logic [MEM_W-1:0] mem_idx(logic [ddrbi_pkg::BANK_W-1:0] b, logic [ROW_W-1:0] r,
                                                logic [ddrbi_pkg::BEAT_W-1:0] beat);
    return {b, r, beat};
  endfunction : mem_idx

  // The strobe is phase-locked to the command clock by the controller, a quarter cycle late, so both
  // captured beats are settled a quarter cycle before the next rising command clock reads them.
  always_ff @(posedge link.write_data_strobe or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_rise_ff <= {ddrbi_pkg::DQ_W{1'b0}};
    end
    else
    begin
      wr_rise_ff <= link.dq;
    end
  end

  always_ff @(negedge link.write_data_strobe or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_fall_ff <= {ddrbi_pkg::DQ_W{1'b0}};
    end
    else
    begin
      wr_fall_ff <= link.dq;
    end
  end

  always_comb
  begin
    nxt_q           = q_ff;
    nxt_q.ref_pulse = 1'b0;
    nxt_q.rd_valid  = 1'b0;
    cmd             = ddrbi_pkg::cmd_decode({link.cs_n, link.we_n, link.ref_n});
    last_pair       = (4'(q_ff.beat) + 4'(ddrbi_pkg::BEATS_PER_CK)) >= ddrbi_pkg::burst_beats(q_ff.bl_code);
    case (q_ff.st)
      D_IDLE:
      begin
        case (cmd)
          ddrbi_pkg::CMD_READ:
          begin
            nxt_q.bank = link.bank;
            nxt_q.row  = link.addr[ROW_W-1:0];
            nxt_q.beat = {ddrbi_pkg::BEAT_W{1'b0}};
            nxt_q.cnt  = 4'(RD_LAT - 1);
            nxt_q.st   = D_READ;
          end
          ddrbi_pkg::CMD_WRITE:
          begin
            nxt_q.bank = link.bank;
            nxt_q.row  = link.addr[ROW_W-1:0];
            nxt_q.beat = {ddrbi_pkg::BEAT_W{1'b0}};
            nxt_q.st   = D_WRITE;
          end
          ddrbi_pkg::CMD_REF:
          begin
            nxt_q.ref_bank  = link.bank;
            nxt_q.ref_row   = q_ff.ref_ctr;
            nxt_q.ref_ctr   = ROW_W'(q_ff.ref_ctr + 1'b1);
            nxt_q.ref_pulse = 1'b1;
          end
          ddrbi_pkg::CMD_MRS:
          begin
            if (link.addr[ddrbi_pkg::MRS_BL_POS +: 2] != ddrbi_pkg::BL_CODE_RSV)
            begin
              nxt_q.bl_code = link.addr[ddrbi_pkg::MRS_BL_POS +: 2];
            end
          end
          default:
          begin
            nxt_q.st = D_IDLE;
          end
        endcase
      end
      D_READ:
      begin
        if (q_ff.cnt != 4'h0)
        begin
          nxt_q.cnt = q_ff.cnt - 4'h1;
        end
        else
        begin
          nxt_q.rd_rise  = q_ff.mem[mem_idx(q_ff.bank, q_ff.row, q_ff.beat)];
          nxt_q.rd_fall  = q_ff.mem[mem_idx(q_ff.bank, q_ff.row, q_ff.beat | 3'h1)];
          nxt_q.rd_valid = 1'b1;
          nxt_q.beat     = q_ff.beat + 3'(ddrbi_pkg::BEATS_PER_CK);
          if (last_pair)
          begin
            nxt_q.st = D_IDLE;
          end
        end
      end
      D_WRITE:
      begin
        nxt_q.mem[mem_idx(q_ff.bank, q_ff.row, q_ff.beat)]        = wr_rise_ff;
        nxt_q.mem[mem_idx(q_ff.bank, q_ff.row, q_ff.beat | 3'h1)] = wr_fall_ff;
        nxt_q.beat = q_ff.beat + 3'(ddrbi_pkg::BEATS_PER_CK);
        if (last_pair)
        begin
          nxt_q.st = D_IDLE;
        end
      end
      default:
      begin
        nxt_q.st = D_IDLE;
      end
    endcase
  end

  always_ff @(posedge link.cmd_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff         <= '0;
      q_ff.st      <= D_IDLE;
      q_ff.bl_code <= ddrbi_pkg::BL_RESET;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Read strobes run free with the command clock, so the controller can train on them between bursts.
  assign link.read_strobe = {ddrbi_pkg::STROBES{link.cmd_clock}};

  // Each nine-line group switches beat on strobe 0 or 1 (per strobe_of_group), so data edges coincide with strobe edges.
  always_comb
  begin
    for (int g = 0; g < ddrbi_pkg::GROUPS; g++)
    begin
      link.dq_dev_out[g*ddrbi_pkg::GROUP_W +: ddrbi_pkg::GROUP_W] =
        link.read_strobe[ddrbi_pkg::strobe_of_group(g)] ?
        q_ff.rd_rise[g*ddrbi_pkg::GROUP_W +: ddrbi_pkg::GROUP_W] :
        q_ff.rd_fall[g*ddrbi_pkg::GROUP_W +: ddrbi_pkg::GROUP_W];
    end
  end

  assign link.dq_dev_oe  = q_ff.rd_valid;
  assign link.data_valid = q_ff.rd_valid;
  assign refresh_pulse   = q_ff.ref_pulse;
  assign refresh_bank    = q_ff.ref_bank;
  assign refresh_row     = q_ff.ref_row;
  assign burst_len       = q_ff.bl_code;
  assign busy            = (q_ff.st != D_IDLE);

endmodule : ddrbi_device

// ===== logic/ddrbi_ctrl.sv
// Memory controller end: makes the command clock and write strobe, issues commands, moves burst data.
`timescale 1ns/1ps
module ddrbi_ctrl #(
  parameter int RD_LAT = ddrbi_pkg::RD_LAT
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  ddrbi_if.ctrl                             link,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire ddrbi_pkg::ddrbi_cmd_e        req_cmd,
  input  wire logic [ddrbi_pkg::BANK_W-1:0] req_bank,
  input  wire logic [ddrbi_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [ddrbi_pkg::DQ_W-1:0]   wr_data,
  output logic                              wr_take,
  output logic [ddrbi_pkg::DQ_W-1:0]        rd_data,
  output logic                              rd_valid,
  output logic                              rd_first,
  output logic [1:0]                        burst_len
);

  if (RD_LAT < 1 || RD_LAT > 15) begin : g_bad_param
    $error("ddrbi_ctrl: RD_LAT must be 1..15");
  end

  typedef enum logic [1:0] {C_IDLE, C_WRITE, C_WAIT} ddrbi_cst_e;

  typedef struct packed {
    logic                         ck;
    ddrbi_cst_e                   st;
    logic [2:0]                   pins;
    logic [ddrbi_pkg::BANK_W-1:0] bank;
    logic [ddrbi_pkg::ADDR_W-1:0] addr;
    logic [1:0]                   bl_code;
    logic [5:0]                   cnt;
    logic [3:0]                   wbeat;
    logic [ddrbi_pkg::DQ_W-1:0]   dq;
    logic                         dq_oe;
    logic [ddrbi_pkg::DQ_W-1:0]   rd_data;
    logic                         rd_valid;
    logic                         rd_first;
  } ddrbi_ctl_s;

  ddrbi_ctl_s                 q_ff;
  ddrbi_ctl_s                 nxt_q;
  logic                       wstb_ff;
  logic [ddrbi_pkg::DQ_W-1:0] cap_dq_ff;
  logic                       cap_vld_ff;
  logic                       cap_rise_ff;
  logic [3:0]                 beats;

  // Sampling on the falling system clock puts the capture in the middle of each half-cycle beat, which
  // stands in for the quarter-cycle strobe delay a real receiver would use.
  always_ff @(negedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wstb_ff     <= 1'b0;
      cap_dq_ff   <= {ddrbi_pkg::DQ_W{1'b0}};
      cap_vld_ff  <= 1'b0;
      cap_rise_ff <= 1'b0;
    end
    else
    begin
      wstb_ff     <= q_ff.ck;
      cap_dq_ff   <= link.dq;
      cap_vld_ff  <= link.data_valid;
      cap_rise_ff <= link.read_strobe[0] & link.read_strobe[1];
    end
  end

  assign beats     = ddrbi_pkg::burst_beats(q_ff.bl_code);
  assign req_ready = (q_ff.st == C_IDLE) && q_ff.ck;
  assign wr_take   = (q_ff.st == C_WRITE);

  always_comb
  begin
    nxt_q          = q_ff;
    nxt_q.ck       = ~q_ff.ck;
    nxt_q.rd_valid = cap_vld_ff;
    nxt_q.rd_first = cap_rise_ff;
    if (cap_vld_ff)
    begin
      nxt_q.rd_data = cap_dq_ff;
    end
    if (q_ff.ck)
    begin
      nxt_q.pins = ddrbi_pkg::PIN_NOP;
    end
    case (q_ff.st)
      C_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          nxt_q.pins = ddrbi_pkg::cmd_encode(req_cmd);
          nxt_q.bank = req_bank;
          nxt_q.addr = req_addr;
          nxt_q.cnt  = 6'(ddrbi_pkg::BEATS_PER_CK);
          nxt_q.st   = C_WAIT;
          case (req_cmd)
            ddrbi_pkg::CMD_WRITE:
            begin
              nxt_q.wbeat = 4'h0;
              nxt_q.st    = C_WRITE;
            end
            ddrbi_pkg::CMD_READ:
            begin
              nxt_q.cnt = 6'(2 * RD_LAT + ddrbi_pkg::BEATS_PER_CK) + 6'(beats);
            end
            ddrbi_pkg::CMD_REF:
            begin
              nxt_q.addr = {ddrbi_pkg::ADDR_W{1'b0}};
            end
            ddrbi_pkg::CMD_MRS:
            begin
              nxt_q.addr[ddrbi_pkg::MRS_DLL_POS] = 1'b1;
              if (req_addr[ddrbi_pkg::MRS_BL_POS +: 2] != ddrbi_pkg::BL_CODE_RSV)
              begin
                nxt_q.bl_code = req_addr[ddrbi_pkg::MRS_BL_POS +: 2];
              end
            end
            default:
            begin
              nxt_q.st = C_WAIT;
            end
          endcase
        end
      end
      C_WRITE:
      begin
        nxt_q.dq    = wr_data;
        nxt_q.dq_oe = 1'b1;
        nxt_q.wbeat = q_ff.wbeat + 4'h1;
        if (q_ff.wbeat == beats - 4'h1)
        begin
          nxt_q.st = C_WAIT;
        end
      end
      C_WAIT:
      begin
        nxt_q.dq_oe = 1'b0;
        if (q_ff.cnt != 6'h0)
        begin
          nxt_q.cnt = q_ff.cnt - 6'h1;
        end
        else
        begin
          nxt_q.st = C_IDLE;
        end
      end
      default:
      begin
        nxt_q.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff         <= '0;
      q_ff.st      <= C_IDLE;
      q_ff.pins    <= ddrbi_pkg::PIN_NOP;
      q_ff.bl_code <= ddrbi_pkg::BL_RESET;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign link.cmd_clock         = q_ff.ck;
  assign link.write_data_strobe = wstb_ff;
  assign {link.cs_n, link.we_n, link.ref_n} = q_ff.pins;
  assign link.bank              = q_ff.bank;
  assign link.addr              = q_ff.addr;
  assign link.dq_ctrl_out       = q_ff.dq;
  assign link.dq_ctrl_oe        = q_ff.dq_oe;
  assign rd_data                = q_ff.rd_data;
  assign rd_valid               = q_ff.rd_valid;
  assign rd_first               = q_ff.rd_first;
  assign burst_len              = q_ff.bl_code;

endmodule : ddrbi_ctrl

// ===== verification/ddrbi_link_asserts.sv
// Concurrent checks on the link between the controller end and the device end.
`timescale 1ns/1ps
module ddrbi_link_asserts #(
  parameter int RD_LAT = ddrbi_pkg::RD_LAT
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic                          cmd_clock,
  input wire logic                          write_data_strobe,
  input wire logic                          cs_n,
  input wire logic                          we_n,
  input wire logic                          ref_n,
  input wire logic [ddrbi_pkg::ADDR_W-1:0]  addr,
  input wire logic                          dq_ctrl_oe,
  input wire logic                          dq_dev_oe,
  input wire logic [ddrbi_pkg::STROBES-1:0] read_strobe,
  input wire logic                          data_valid
);
  logic [2:0] pins;
  assign pins = {cs_n, we_n, ref_n};

  a_strobe_track: assert property (@(posedge sys_clk) disable iff (!rst_n)
    read_strobe == {ddrbi_pkg::STROBES{cmd_clock}})
    else $error("read strobes do not follow the command clock");
  a_clk_divides: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n && $past(rst_n) |-> cmd_clock != $past(cmd_clock))
    else $error("command clock missed a toggle");
  a_wstrobe_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_data_strobe == cmd_clock)
    else $error("write strobe not a quarter cycle behind the command clock");
  a_cmd_once: assert property (@(posedge cmd_clock) disable iff (!rst_n)
    pins != ddrbi_pkg::PIN_NOP |=> pins == ddrbi_pkg::PIN_NOP)
    else $error("command held for more than one command cycle");
  a_wr_drive: assert property (@(posedge cmd_clock) disable iff (!rst_n)
    pins == ddrbi_pkg::PIN_WRITE |=> dq_ctrl_oe && !dq_dev_oe)
    else $error("write data not driven by the controller");
  a_rd_latency: assert property (@(posedge cmd_clock) disable iff (!rst_n)
    pins == ddrbi_pkg::PIN_READ |-> ##RD_LAT !data_valid ##1 (data_valid && dq_dev_oe))
    else $error("read data not valid at the read latency");
  a_ref_addr: assert property (@(posedge cmd_clock) disable iff (!rst_n)
    pins == ddrbi_pkg::PIN_REF |-> addr == '0)
    else $error("refresh carries an address");
  a_dll_on: assert property (@(posedge cmd_clock) disable iff (!rst_n)
    pins == ddrbi_pkg::PIN_MRS |-> addr[ddrbi_pkg::MRS_DLL_POS])
    else $error("mode set without the delay-locked loop enabled");
  a_dv_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cmd_clock |-> $stable(data_valid))
    else $error("data valid changed inside a command cycle");
endmodule : ddrbi_link_asserts

// ===== verification/ddrbi_tb.sv
// Self-checking bench joining the controller end to the device end over the link.
`timescale 1ns/1ps
module testbench;
  logic                  sys_clk;
  logic                  rst_n;
  logic                  req_valid;
  logic                  req_ready;
  ddrbi_pkg::ddrbi_cmd_e req_cmd;
  logic [3:0]            req_bank;
  logic [19:0]           req_addr;
  logic [35:0]           wr_data;
  logic                  wr_take;
  logic [35:0]           rd_data;
  logic                  rd_valid;
  logic                  rd_first;
  logic [1:0]            ctrl_bl;
  logic [1:0]            dev_bl;
  logic                  dev_busy;
  logic                  refresh_pulse;
  logic [3:0]            refresh_bank;
  logic [1:0]            refresh_row;
  logic [7:0]            wseed;
  logic [3:0]            wbeat;
  logic                  take_mid;
  logic [35:0]           rdq[$];
  logic                  fq[$];
  int                    dvcnt;
  int                    nref;
  logic [3:0]            rbank;
  logic [1:0]            rrow;
  int                    miscompares;
  int                    n_checks;

  ddrbi_if link_if ();
  ddrbi_ctrl #(.RD_LAT(ddrbi_pkg::RD_LAT)) ddrbi_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .rd_first(rd_first),
    .burst_len(ctrl_bl));
  ddrbi_device #(.ROW_W(2), .RD_LAT(ddrbi_pkg::RD_LAT)) ddrbi_device_inst (.link(link_if), .rst_n(rst_n),
    .refresh_pulse(refresh_pulse), .refresh_bank(refresh_bank), .refresh_row(refresh_row),
    .burst_len(dev_bl), .busy(dev_busy));
  ddrbi_link_asserts #(.RD_LAT(ddrbi_pkg::RD_LAT)) ddrbi_link_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_clock(link_if.cmd_clock), .write_data_strobe(link_if.write_data_strobe), .cs_n(link_if.cs_n),
    .we_n(link_if.we_n), .ref_n(link_if.ref_n), .addr(link_if.addr), .dq_ctrl_oe(link_if.dq_ctrl_oe),
    .dq_dev_oe(link_if.dq_dev_oe), .read_strobe(link_if.read_strobe), .data_valid(link_if.data_valid));

  // Every nine-bit group differs, so a swapped group or beat shows up in the data.
  function automatic logic [35:0] pat(input logic [7:0] s, input logic [3:0] b);
    return {s, b, ~s, b, s, b ^ 4'h9};
  endfunction : pat

  assign wr_data = pat(wseed, wbeat);

  // The take flag is combinational, so it is sampled mid-cycle to avoid racing the edge that consumes the beat.
  always @(negedge sys_clk)
  begin
    take_mid <= wr_take;
    if (rd_valid === 1'b1)
    begin
      rdq.push_back(rd_data);
      fq.push_back(rd_first);
    end
  end

  always @(posedge sys_clk)
    if (take_mid === 1'b1)
      wbeat <= wbeat + 4'h1;

  always @(negedge link_if.cmd_clock)
  begin
    if (link_if.data_valid === 1'b1)
      dvcnt++;
    if (refresh_pulse === 1'b1)
    begin
      nref++;
      rbank = refresh_bank;
      rrow = refresh_row;
    end
  end

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic issue(input ddrbi_pkg::ddrbi_cmd_e c, input logic [3:0] b, input logic [19:0] a);
    int k;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    @(negedge sys_clk);
    for (k = 0; k < 200 && req_ready !== 1'b1; k++)
      @(negedge sys_clk);
    chk("request accepted", 36'h1, 36'(k < 200));
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : issue

  task automatic do_write(input logic [3:0] b, input logic [19:0] a, input logic [7:0] s, input int n);
    int k;
    @(posedge sys_clk);
    wseed <= s;
    wbeat <= 4'h0;
    issue(ddrbi_pkg::CMD_WRITE, b, a);
    for (k = 0; k < 100 && wbeat != 4'(n); k++)
      @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    chk("write beats", 36'(n), 36'(wbeat));
  endtask : do_write

  task automatic do_read(input logic [3:0] b, input logic [19:0] a, input logic [7:0] s, input int n);
    int k;
    logic [35:0] e;
    rdq.delete();
    fq.delete();
    dvcnt = 0;
    issue(ddrbi_pkg::CMD_READ, b, a);
    for (k = 0; k < 100 && rdq.size() < n; k++)
      @(negedge sys_clk);
    repeat (6) @(negedge sys_clk);
    chk("read beats", 36'(n), 36'(rdq.size()));
    chk("valid cycles", 36'(n / 2), 36'(dvcnt));
    for (k = 0; k < rdq.size(); k++)
    begin
      e = pat(s, 4'(k));
      chk("read data", e, rdq[k]);
      chk("strobe 1 groups", 36'({e[35:27], e[17:9]}), 36'({rdq[k][35:27], rdq[k][17:9]}));
      chk("first beat", 36'(k % 2 == 0), 36'(fq[k]));
    end
  endtask : do_read

  // Mode set occupies the controller for three cycles; six leaves margin for the clock phase.
  task automatic set_bl(input logic [1:0] code);
    issue(ddrbi_pkg::CMD_MRS, 4'h0, {18'h0, code});
    repeat (6) @(negedge sys_clk);
  endtask : set_bl

  task automatic t_modes();
    logic [1:0] codes [3] = '{ddrbi_pkg::BL_CODE_4, ddrbi_pkg::BL_CODE_8, ddrbi_pkg::BL_CODE_2};
    for (int i = 0; i < 3; i++)
    begin
      set_bl(codes[i]);
      chk("ctrl burst code", 36'(codes[i]), 36'(ctrl_bl));
      chk("device burst code", 36'(codes[i]), 36'(dev_bl));
      do_write(4'(i + 5), 20'(i), 8'(8'h30 + i), 2 << codes[i]);
      do_read(4'(i + 5), 20'(i), 8'(8'h30 + i), 2 << codes[i]);
    end
    set_bl(ddrbi_pkg::BL_CODE_RSV);
    chk("reserved code", 36'(ddrbi_pkg::BL_CODE_2), 36'(dev_bl));
    chk("ctrl reserved code", 36'(ddrbi_pkg::BL_CODE_2), 36'(ctrl_bl));
  endtask : t_modes

  task automatic t_banks();
    set_bl(ddrbi_pkg::BL_CODE_8);
    do_write(4'h0, 20'hFFFF1, 8'hA5, 8);
    do_write(4'hF, 20'hFFFF1, 8'h5A, 8);
    do_read(4'h0, 20'hFFFF1, 8'hA5, 8);
    do_read(4'hF, 20'hFFFF1, 8'h5A, 8);
  endtask : t_banks

  task automatic t_refresh();
    int k;
    int n0;
    for (int i = 0; i < 5; i++)
    begin
      n0 = nref;
      issue(ddrbi_pkg::CMD_REF, 4'(3 * i), 20'hFFFFF);
      for (k = 0; k < 50 && nref == n0; k++)
        @(negedge sys_clk);
      repeat (4) @(negedge sys_clk);
      chk("refresh pulses", 36'(n0 + 1), 36'(nref));
      chk("refresh bank", 36'(3 * i), 36'(rbank));
      chk("refresh row", 36'(i % 4), 36'(rrow));
    end
  endtask : t_refresh

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #100000;
    miscompares++;
    $display("[FAIL] run time expected finish seen timeout");
    wrap_up();
  end

  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = ddrbi_pkg::CMD_NOP;
    req_bank = 4'h0;
    req_addr = 20'h0;
    wseed = 8'h0;
    wbeat = 4'h0;
    take_mid = 1'b0;
    dvcnt = 0;
    nref = 0;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("reset burst code", 36'({ddrbi_pkg::BL_RESET, ddrbi_pkg::BL_RESET}), 36'({ctrl_bl, dev_bl}));
    chk("reset busy", 36'h0, 36'(dev_busy));
    t_modes();
    t_banks();
    t_refresh();
    wrap_up();
  end
endmodule : testbench
